// File: rtl/ext_bus_params.svh
// Purpose: offsets, field positions, reset values and cycle counts
// Assumes: one pclk cycle is one bus clock cycle
// Notes: included by the cycle code decoder, the strobe controller and the bench
`ifndef EXT_BUS_PARAMS_SVH
`define EXT_BUS_PARAMS_SVH

`define EB_CFG0_OFS 8'h00
`define EB_CFG1_OFS 8'h04
`define EB_CFG2_OFS 8'h08
`define EB_CFG3_OFS 8'h0C
`define EB_MODE_OFS 8'h10
`define EB_STAT_OFS 8'h14

`define EB_CFG_RST 8'h03
`define EB_CFG_WMASK 8'h5F
`define EB_REC_BIT 6
`define EB_CODE_DEF 5'h03

`define EB_MODE_RST 8'h00
`define EB_MODE_WMASK 8'hFF
`define EB_MEMW_BIT 0
`define EB_SFRW_BIT 1
`define EB_STYLE_BIT 2
`define EB_MUX_BIT 3
`define EB_WIDTH_LSB 4

`define EB_CTL_RST 8'h00
`define EB_CTLW_PLL_BIT 0
`define EB_CTLW_FLASH_BIT 1
`define EB_CTL_OFS 8'h18

`define EB_INT_FAST 3'h1
`define EB_INT_SLOW 3'h2
`define EB_SFR_FAST 3'h2
`define EB_SFR_SLOW 3'h3

`endif

// File: rtl/ext_bus_pkg.sv
// Purpose: types shared by the external bus strobe controller
// Assumes: nothing
// Notes: constants live in ext_bus_params.svh
package ext_bus_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PHASE1,
      ST_PHASE2,
      ST_RECOVER,
      ST_INTERNAL
   } bus_state_e;

   typedef logic [2:0] target_t;
   localparam target_t TGT_ROM = 3'h4;
   localparam target_t TGT_RAM = 3'h5;
   localparam target_t TGT_SFR = 3'h6;
endpackage

// File: rtl/cycle_code_decode.sv
// Purpose: split a cycle select code into first and second phase counts
// Assumes: code from space_cycle_cfg bits 4..0
// Notes: invalid codes flag valid low and give the reset timing
`timescale 1ns/10ps
`default_nettype none
`include "ext_bus_params.svh"
module cycle_code_decode (
   input wire logic [4:0] code,
   input wire logic mux_bus,
   output logic [1:0] first_cnt,
   output logic [2:0] second_cnt,
   output logic valid
);
   logic [4:0] used;

   always_comb begin
      valid = 1'b0;
      if (mux_bus) begin
         case (code)
            5'h0A, 5'h0B, 5'h0D, 5'h13, 5'h14, 5'h15, 5'h16: valid = 1'b1;
            default: valid = 1'b0;
         endcase
      end else begin
         case (code)
            5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
            5'h0A, 5'h0B, 5'h0C, 5'h13, 5'h14, 5'h16: valid = 1'b1;
            default: valid = 1'b0;
         endcase
      end
      // fall back to 1+3 so a bad code never gives a zero phase
      used = valid ? code : `EB_CODE_DEF;
      first_cnt = used[4:3] + 2'h1;
      second_cnt = used[2:0];
   end
endmodule
`default_nettype wire

// File: rtl/ext_bus_strobe_ctrl.sv
// Purpose: external bus strobes and bus cycle timing with APB registers
// Assumes: one pclk cycle equals one bus clock cycle
// Notes: request taken when req_valid and req_ready at a rising edge
//
// Behaviour
// - odd byte write: wr low, bhe low, a0 high
// - odd byte read: rd low, bhe low, a0 high
// - even byte write: wr low, bhe high, a0 low
// - even byte read: rd low, bhe high, a0 low
// - word write: wr low, bhe low, a0 low
// - word read: rd low, bhe low, a0 low
// - internal rom/ram one or two cycles
// - pll normal-speed rom block reads take two
// - sfr accesses take two or three cycles
// - external cycle is first then second phase
// - external access at least one plus one
// - separate bus twelve cycle codes
// - multiplexed bus seven cycle codes
// - four per-space cycle configuration registers
// - bit six appends a recovery cycle
// - bits five and seven unimplemented
// - recovery cycle holds address and data
// - style bit picks single or split write strobes
// - chip select low only for its space
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "ext_bus_params.svh"
module ext_bus_strobe_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [2:0] req_target,
   input wire logic req_rom_ab,
   input wire logic [23:0] req_addr,
   input wire logic [1:0] req_be,
   input wire logic [15:0] req_wdata,
   output logic req_done,
   output logic [23:1] addr_out,
   output logic byte_address_bit,
   output logic [15:0] data_out,
   output logic data_oe_n,
   output logic rd_n,
   output logic wr_n,
   output logic high_byte_lane_enable_n,
   output logic low_lane_write_n,
   output logic high_lane_write_n,
   output logic [3:0] cs_n
);
   typedef struct packed {
      ext_bus_pkg::bus_state_e state;
      logic [2:0] cnt;
      logic [3:0][7:0] cfg;
      logic [7:0] mode;
      logic [7:0] ctl;
      logic bad_code;
      logic [1:0] space;
      logic write;
      logic [1:0] be;
      logic wide;
      logic done;
      logic [23:1] addr;
      logic a0;
      logic [15:0] wdata;
      logic oe_n;
      logic rd_n;
      logic wr_n;
      logic bhe_n;
      logic wrl_n;
      logic wrh_n;
      logic [3:0] cs_n;
   } state_s;

   state_s r_reg;
   state_s r_next;
   logic [1:0] dec_space;
   logic [1:0] first_cnt;
   logic [2:0] second_cnt;
   logic code_valid;
   logic apb_wr;
   logic hit;
   logic style_split;

   assign dec_space = (r_reg.state == ext_bus_pkg::ST_IDLE) ?
                      req_target[1:0] : r_reg.space;

   cycle_code_decode u_decode (
      .code(r_reg.cfg[dec_space][4:0]),
      .mux_bus(r_reg.mode[`EB_MUX_BIT]),
      .first_cnt(first_cnt),
      .second_cnt(second_cnt),
      .valid(code_valid)
   );

   assign req_ready = (r_reg.state == ext_bus_pkg::ST_IDLE);
   assign apb_wr = psel && penable && pwrite;
   assign pready = 1'b1;
   assign style_split = r_reg.mode[`EB_STYLE_BIT];

   always_comb begin
      hit = 1'b1;
      prdata = 32'h0000_0000;
      case (paddr)
         `EB_CFG0_OFS: prdata = {24'h0, r_reg.cfg[0] & `EB_CFG_WMASK};
         `EB_CFG1_OFS: prdata = {24'h0, r_reg.cfg[1] & `EB_CFG_WMASK};
         `EB_CFG2_OFS: prdata = {24'h0, r_reg.cfg[2] & `EB_CFG_WMASK};
         `EB_CFG3_OFS: prdata = {24'h0, r_reg.cfg[3] & `EB_CFG_WMASK};
         `EB_MODE_OFS: prdata = {24'h0, r_reg.mode};
         `EB_CTL_OFS: prdata = {24'h0, r_reg.ctl};
         `EB_STAT_OFS: prdata = {27'h0, r_reg.state, r_reg.bad_code,
                                 !req_ready};
         default: hit = 1'b0;
      endcase
      pslverr = psel && penable && !hit;
   end

   always_comb begin
      r_next = r_reg;
      r_next.done = 1'b0;
      if (apb_wr) begin
         case (paddr)
            `EB_CFG0_OFS: r_next.cfg[0] = pwdata[7:0] & `EB_CFG_WMASK;
            `EB_CFG1_OFS: r_next.cfg[1] = pwdata[7:0] & `EB_CFG_WMASK;
            `EB_CFG2_OFS: r_next.cfg[2] = pwdata[7:0] & `EB_CFG_WMASK;
            `EB_CFG3_OFS: r_next.cfg[3] = pwdata[7:0] & `EB_CFG_WMASK;
            `EB_MODE_OFS: r_next.mode = pwdata[7:0];
            `EB_CTL_OFS: r_next.ctl = pwdata[7:0];
            `EB_STAT_OFS: if (pwdata[1]) r_next.bad_code = 1'b0;
            default: r_next.mode = r_reg.mode;
         endcase
      end
      case (r_reg.state)
         ext_bus_pkg::ST_IDLE: begin
            if (req_valid) begin
               r_next.write = req_write;
               r_next.be = req_be;
               r_next.space = req_target[1:0];
               if (!req_target[2]) begin
                  // set wins over a same-cycle software clear
                  if (!code_valid) r_next.bad_code = 1'b1;
                  r_next.wide = r_reg.mode[`EB_WIDTH_LSB + req_target[1:0]];
                  r_next.state = ext_bus_pkg::ST_PHASE1;
                  r_next.cnt = {1'b0, first_cnt} - 3'h1;
                  r_next.cs_n = ~(4'h1 << req_target[1:0]);
                  r_next.addr = req_addr[23:1];
                  r_next.wdata = req_wdata;
                  r_next.oe_n = !req_write;
                  if (r_reg.mode[`EB_WIDTH_LSB + req_target[1:0]]) begin
                     // 16-bit lanes: a0 only for a lone odd byte
                     r_next.a0 = (req_be == 2'b10);
                     r_next.bhe_n = !req_be[1];
                  end else begin
                     r_next.a0 = req_addr[0];
                     r_next.bhe_n = 1'b1;
                  end
               end else begin
                  r_next.state = ext_bus_pkg::ST_INTERNAL;
                  case (req_target)
                     ext_bus_pkg::TGT_SFR:
                        r_next.cnt = (r_reg.mode[`EB_SFRW_BIT] ?
                           `EB_SFR_SLOW : `EB_SFR_FAST) - 3'h1;
                     ext_bus_pkg::TGT_ROM:
                        r_next.cnt = ((r_reg.ctl[`EB_CTLW_PLL_BIT] &&
                           !r_reg.ctl[`EB_CTLW_FLASH_BIT] && req_rom_ab &&
                           !req_write) || r_reg.mode[`EB_MEMW_BIT]) ?
                           `EB_INT_SLOW - 3'h1 : `EB_INT_FAST - 3'h1;
                     default:
                        r_next.cnt = (r_reg.mode[`EB_MEMW_BIT] ?
                           `EB_INT_SLOW : `EB_INT_FAST) - 3'h1;
                  endcase
               end
            end
         end
         ext_bus_pkg::ST_PHASE1: begin
            if (r_reg.cnt == 3'h0) begin
               r_next.state = ext_bus_pkg::ST_PHASE2;
               r_next.cnt = second_cnt - 3'h1;
               if (!r_reg.write) begin
                  r_next.rd_n = 1'b0;
               end else if (r_reg.wide && style_split) begin
                  r_next.wrl_n = !r_reg.be[0];
                  r_next.wrh_n = !r_reg.be[1];
                  r_next.bhe_n = 1'b1;
               end else begin
                  r_next.wr_n = 1'b0;
               end
            end else begin
               r_next.cnt = r_reg.cnt - 3'h1;
            end
         end
         ext_bus_pkg::ST_PHASE2: begin
            if (r_reg.cnt == 3'h0) begin
               r_next.rd_n = 1'b1;
               r_next.wr_n = 1'b1;
               r_next.wrl_n = 1'b1;
               r_next.wrh_n = 1'b1;
               r_next.cs_n = 4'hF;
               if (r_reg.cfg[r_reg.space][`EB_REC_BIT]) begin
                  // address and write data stay put for slow holds
                  r_next.state = ext_bus_pkg::ST_RECOVER;
               end else begin
                  r_next.state = ext_bus_pkg::ST_IDLE;
                  r_next.oe_n = 1'b1;
                  r_next.done = 1'b1;
               end
            end else begin
               r_next.cnt = r_reg.cnt - 3'h1;
            end
         end
         ext_bus_pkg::ST_RECOVER: begin
            r_next.state = ext_bus_pkg::ST_IDLE;
            r_next.oe_n = 1'b1;
            r_next.done = 1'b1;
         end
         ext_bus_pkg::ST_INTERNAL: begin
            // pins keep the last external address and bhe level
            if (r_reg.cnt == 3'h0) begin
               r_next.state = ext_bus_pkg::ST_IDLE;
               r_next.done = 1'b1;
            end else begin
               r_next.cnt = r_reg.cnt - 3'h1;
            end
         end
         default: r_next.state = ext_bus_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= '0;
         r_reg.state <= ext_bus_pkg::ST_IDLE;
         r_reg.cfg <= {4{`EB_CFG_RST}};
         r_reg.mode <= `EB_MODE_RST;
         r_reg.ctl <= `EB_CTL_RST;
         r_reg.oe_n <= 1'b1;
         r_reg.rd_n <= 1'b1;
         r_reg.wr_n <= 1'b1;
         r_reg.bhe_n <= 1'b1;
         r_reg.wrl_n <= 1'b1;
         r_reg.wrh_n <= 1'b1;
         r_reg.cs_n <= 4'hF;
      end else begin
         r_reg <= r_next;
      end
   end

   assign req_done = r_reg.done;
   assign addr_out = r_reg.addr;
   assign byte_address_bit = r_reg.a0;
   assign data_out = r_reg.wdata;
   assign data_oe_n = r_reg.oe_n;
   assign rd_n = r_reg.rd_n;
   assign wr_n = r_reg.wr_n;
   assign high_byte_lane_enable_n = r_reg.bhe_n;
   assign low_lane_write_n = r_reg.wrl_n;
   assign high_lane_write_n = r_reg.wrh_n;
   assign cs_n = r_reg.cs_n;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic in_p2;
   logic take_ext;
   assign in_p2 = (r_reg.state == ext_bus_pkg::ST_PHASE2);
   assign take_ext = req_ready && req_valid && !req_target[2];

   a_odd_write: assert property (in_p2 && r_reg.write && r_reg.wide &&
      !style_split && r_reg.be == 2'b10 |-> !wr_n && rd_n &&
      !high_byte_lane_enable_n && byte_address_bit)
      else $error("odd byte write strobes wrong");
   a_odd_read: assert property (in_p2 && !r_reg.write && r_reg.wide &&
      r_reg.be == 2'b10 |-> !rd_n && wr_n && !high_byte_lane_enable_n &&
      byte_address_bit) else $error("odd byte read strobes wrong");
   a_even_write: assert property (in_p2 && r_reg.write && r_reg.wide &&
      !style_split && r_reg.be == 2'b01 |-> !wr_n && rd_n &&
      high_byte_lane_enable_n && !byte_address_bit)
      else $error("even byte write strobes wrong");
   a_even_read: assert property (in_p2 && !r_reg.write && r_reg.wide &&
      r_reg.be == 2'b01 |-> !rd_n && wr_n && high_byte_lane_enable_n &&
      !byte_address_bit) else $error("even byte read strobes wrong");
   a_word_write: assert property (in_p2 && r_reg.write && r_reg.wide &&
      !style_split && r_reg.be == 2'b11 |-> !wr_n && rd_n &&
      !high_byte_lane_enable_n && !byte_address_bit)
      else $error("word write strobes wrong");
   a_word_read: assert property (in_p2 && !r_reg.write && r_reg.wide &&
      r_reg.be == 2'b11 |-> !rd_n && wr_n && !high_byte_lane_enable_n &&
      !byte_address_bit) else $error("word read strobes wrong");
   a_ram_fast: assert property (req_ready && req_valid &&
      req_target == ext_bus_pkg::TGT_RAM && !r_reg.mode[`EB_MEMW_BIT]
      |=> !req_done ##1 req_done) else $error("ram access not one cycle");
   a_sfr_slow: assert property (req_ready && req_valid &&
      req_target == ext_bus_pkg::TGT_SFR && r_reg.mode[`EB_SFRW_BIT]
      |=> !req_done [*3] ##1 req_done) else $error("sfr access not three");

   sequence s_phase1_one;
      rd_n && wr_n && low_lane_write_n && high_lane_write_n &&
         (cs_n != 4'hF);
   endsequence
   // split lane strobes count as the strobe too
   sequence s_phase2_three;
      (!rd_n || !wr_n || !low_lane_write_n || !high_lane_write_n) [*3];
   endsequence
   a_code_1p3: assert property (take_ext && !r_reg.mode[`EB_MUX_BIT] &&
      r_reg.cfg[req_target[1:0]][4:0] == 5'h03
      |=> s_phase1_one ##1 s_phase2_three ##1 (rd_n && wr_n))
      else $error("1+3 cycle timing wrong");
   a_recover_hold: assert property (
      r_reg.state == ext_bus_pkg::ST_RECOVER |-> $stable(addr_out) &&
      $stable(data_out) && !data_oe_n == r_reg.write)
      else $error("recovery did not hold bus");
   a_cs_onehot: assert property ($onehot0(~cs_n))
      else $error("more than one chip select");
endmodule
`default_nettype wire

// File: bench/ext_dev_model.sv
// Purpose: external device on the parallel bus, times every access
// Assumes: controller pins are registered, sampled at pclk rise
// Notes: holds no data; reports phase counts and strobe levels
`timescale 1ns/10ps
`default_nettype none
module ext_dev_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] cs_n,
   input wire logic [5:0] pins,
   output logic [3:0] f_len,
   output logic [3:0] s_len,
   output logic [5:0] seen,
   output logic [3:0] seen_cs,
   output logic [7:0] n_xfer
);
   logic act, act_q, strb;
   logic [3:0] f_c, s_c;
   assign act = ~&cs_n;
   // pins: rd, wr, high lane enable, a0, low lane wr, high lane wr
   assign strb = ~pins[5] | ~pins[4] | ~pins[1] | ~pins[0];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {act_q, f_c, s_c, f_len, s_len, n_xfer} <= '0;
         {seen, seen_cs} <= '1;
      end else begin
         act_q <= act;
         // a select that opens a cycle counts as its first clock
         f_c <= (act && !act_q) ? {3'h0, !strb} :
            f_c + {3'h0, act && !strb};
         s_c <= (act && !act_q) ? {3'h0, strb} :
            s_c + {3'h0, act && strb};
         if (act && strb) {seen, seen_cs} <= {pins, cs_n};
         if (!act && act_q) begin
            f_len <= f_c;
            s_len <= s_c;
            n_xfer <= n_xfer + 8'h1;
         end
      end
   end
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Purpose: self-checking bench for the external bus strobe controller
// Assumes: one pclk per bus clock; device model watches the pins
// Notes: latency is edges from the take edge to the one raising req_done
`timescale 1ns/10ps
`default_nettype none
`include "ext_bus_params.svh"
module tb_top;
   logic pclk = 1'b0, presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, q;
   logic pready, pslverr, req_ready, req_done, err, w, oe;
   logic req_valid = 1'b0, req_write = 1'b0, req_rom_ab = 1'b0;
   logic [2:0] req_target = '0;
   logic [23:0] req_addr = '0;
   logic [1:0] req_be = '0;
   logic [15:0] req_wdata = '0;
   logic [23:1] addr_out;
   logic [15:0] data_out;
   logic byte_address_bit, data_oe_n, rd_n, wr_n;
   logic high_byte_lane_enable_n, low_lane_write_n, high_lane_write_n;
   logic [3:0] cs_n, f_len, s_len, seen_cs;
   logic [5:0] seen;
   logic [7:0] n_xfer, n0;
   logic [23:0] a;
   logic [4:0] c;
   logic [1:0] be;
   logic rab = 1'b0;
   int n_errors = 0, checks = 0, cyc = 0, lat, lat0, s;
   logic [4:0] codes [19] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
      5'h0A, 5'h0B, 5'h0C, 5'h13, 5'h14, 5'h16, 5'h0A, 5'h0B, 5'h0D,
      5'h13, 5'h14, 5'h15, 5'h16};

   ext_bus_strobe_ctrl u_ext_bus_strobe_ctrl (.pclk, .presetn, .paddr,
      .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .req_valid, .req_ready, .req_write, .req_target, .req_rom_ab,
      .req_addr, .req_be, .req_wdata, .req_done, .addr_out,
      .byte_address_bit, .data_out, .data_oe_n, .rd_n, .wr_n,
      .high_byte_lane_enable_n, .low_lane_write_n, .high_lane_write_n,
      .cs_n);
   ext_dev_model u_ext_dev_model (.pclk, .presetn, .cs_n,
      .pins({rd_n, wr_n, high_byte_lane_enable_n, byte_address_bit,
      low_lane_write_n, high_lane_write_n}), .f_len, .s_len, .seen,
      .seen_cs, .n_xfer);

   task automatic give_verdict();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_pins(input logic [5:0] mask, input logic [5:0] exp);
      chk({26'h0, seen & mask}, {26'h0, exp});
   endtask
   function automatic logic [5:0] exp_pins(input logic wr, b1, odd);
      return {wr, !wr, !b1, odd, 2'b00};
   endfunction
   task automatic done_test(input string name);
      $display("test %s done, checks=%0d errors=%0d", name, checks, n_errors);
   endtask
   task automatic apb(input logic wr, input logic [7:0] ad,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // pready is tied high, so this wait ends at the first edge
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic req(input logic wr, input logic [2:0] t,
         input logic [23:0] ad, input logic [1:0] b);
      @(posedge pclk);
      req_valid <= 1'b1;
      req_write <= wr;
      req_target <= t;
      req_addr <= ad;
      req_be <= b;
      req_wdata <= 16'($urandom);
      req_rom_ab <= rab;
      do @(negedge pclk); while (req_ready !== 1'b1);
      @(posedge pclk);
      req_valid <= 1'b0;
      // done rises just after edge n, so it shows at negedge n+1
      lat = -1;
      do begin
         @(negedge pclk);
         lat++;
         if (lat == 0) oe = data_oe_n;
      end while (req_done !== 1'b1);
      // one more edge lets the model publish the finished cycle
      @(posedge pclk);
      @(negedge pclk);
   endtask

   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         give_verdict();
      end
   end

   initial begin
      void'($urandom(98489));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 8'(4 * i), '0);
         chk(q, 32'h03);
      end
      apb(1'b1, `EB_CFG1_OFS, 32'h46);
      apb(1'b0, `EB_CFG1_OFS, '0);
      chk(q, 32'h46);
      apb(1'b0, 8'h1C, '0);
      chk({31'h0, err}, 32'h1);
      done_test("registers");
      // spaces 0..2 on 16 bits, space 3 on 8 bits
      apb(1'b1, `EB_MODE_OFS, 32'h70);
      apb(1'b1, `EB_CFG0_OFS, 32'h01);
      apb(1'b1, `EB_CFG3_OFS, 32'h01);
      for (int i = 0; i < 6; i++) begin
         w = !i[0];
         be = (i < 2) ? 2'h2 : (i < 4) ? 2'h1 : 2'h3;
         req(w, 3'h0, {23'($urandom), i < 2}, be);
         chk_pins(6'h3C, exp_pins(w, be[1], i < 2));
         chk({31'h0, oe}, {31'h0, !w});
      end
      for (int i = 0; i < 2; i++) begin
         a = 24'($urandom);
         req(i[0], 3'h3, a, 2'h1);
         chk_pins(6'h3C, exp_pins(i[0], 1'b0, a[0]));
         chk({31'h0, oe}, {31'h0, !i[0]});
      end
      apb(1'b1, `EB_MODE_OFS, 32'h74);
      for (int i = 1; i < 4; i++) begin
         be = 2'(i);
         req(1'b1, 3'h0, 24'h000100, be);
         chk_pins(6'h23, {4'h8, !be[0], !be[1]});
      end
      done_test("strobes");
      apb(1'b1, `EB_MODE_OFS, 32'h70);
      for (int i = 0; i < 19; i++) begin
         if (i == 12) apb(1'b1, `EB_MODE_OFS, 32'h78);
         s = $urandom_range(3);
         c = codes[i];
         apb(1'b1, 8'(4 * s), {27'h0, c});
         req(1'($urandom), 3'(s), 24'($urandom), (s == 3) ? 2'h1 : 2'h3);
         chk({28'h0, f_len}, {30'h0, c[4:3]} + 32'h1);
         chk({28'h0, s_len}, {29'h0, c[2:0]});
         chk({28'h0, seen_cs}, {28'h0, ~(4'h1 << s)});
      end
      done_test("cycle codes");
      apb(1'b1, `EB_MODE_OFS, 32'h70);
      for (int i = 0; i < 4; i++) apb(1'b1, 8'(4 * i), {27'h0, codes[i]});
      for (int i = 3; i >= 0; i--) begin
         req(1'b0, 3'(i), 24'($urandom), (i == 3) ? 2'h1 : 2'h3);
         chk({28'h0, s_len}, {29'h0, codes[i][2:0]});
      end
      a = 24'($urandom);
      req(1'b1, 3'h2, a, 2'h3);
      lat0 = lat;
      apb(1'b1, `EB_CFG2_OFS, 32'h43);
      req(1'b1, 3'h2, a, 2'h3);
      chk(32'(lat), 32'(lat0 + 1));
      chk({28'h0, s_len}, 32'h3);
      chk({9'h0, addr_out}, {9'h0, a[23:1]});
      chk({16'h0, data_out}, {16'h0, req_wdata});
      done_test("spaces and recovery");
      n0 = n_xfer;
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, `EB_MODE_OFS, 32'h70 | 32'(m));
         req(1'b0, ext_bus_pkg::TGT_ROM, 24'h0, 2'h3);
         chk(32'(lat), m[0] ? 32'h2 : 32'h1);
         req(1'b1, ext_bus_pkg::TGT_RAM, 24'h0, 2'h3);
         chk(32'(lat), m[0] ? 32'h2 : 32'h1);
         req(1'b0, ext_bus_pkg::TGT_SFR, 24'h0, 2'h3);
         chk(32'(lat), m[1] ? 32'h3 : 32'h2);
      end
      apb(1'b1, `EB_MODE_OFS, 32'h70);
      rab = 1'b1;
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, `EB_CTL_OFS, 32'(m));
         req(1'b0, ext_bus_pkg::TGT_ROM, 24'h0, 2'h3);
         chk(32'(lat), (m == 1) ? 32'h2 : 32'h1);
      end
      chk({24'h0, n_xfer}, {24'h0, n0});
      done_test("internal lengths");
      give_verdict();
   end
endmodule
`default_nettype wire
